// File: logic/ama_pkg.sv
/*
 * constants, modes and carriers for the address generator.
 * assumes one core clock and that the decoder hands over
 * register values together with each request.
 */
// Function
// (R1) mac w8/w9 to x read, w10/w11 to y
// (R2) mac indexed only via w9 and w11
// (R3) mac: indirect, indexed, post add 2/4/6
// (R4) one shared offset field for move operands
// (R5) move source and destination modes independent
// (R6) move/accumulator full addressing mode set
// (R7) branch literal signed 16, hold literal 14
// (R8) one circular buffer per x and y
// (R9) x modulo also covers program pointers
// (R10) start/end registers per space, 16 bits
// (R11) length from end minus start, bounded
// (R12) y modulo addresses are word aligned
// (R13) x modulo needs bit 15, select not 1111
// (R14) y modulo needs bit 14, select not 1111
// (R15) software keeps odd buffers one-directional
// (R16) both boundaries checked every update; code checks only the end on increments and only the start on decrements
// (R17) any register selectable, avoid frame/stack pointers
// (R18) past end wraps to start, under start to end
// (R19) only the selected pointer is corrected
package ama_pkg;

    // ***************************************************
    // register indices and reset values
    // ***************************************************
    localparam logic [2:0]  CTRL_IDX   = 3'h0;
    localparam logic [2:0]  XS_IDX     = 3'h1;
    localparam logic [2:0]  XE_IDX     = 3'h2;
    localparam logic [2:0]  YS_IDX     = 3'h3;
    localparam logic [2:0]  YE_IDX     = 3'h4;
    localparam logic [2:0]  STAT_IDX   = 3'h5;
    localparam logic [15:0] CTRL_RESET = 16'h00ff;
    localparam logic [15:0] BUF_RESET  = 16'h0000;
    localparam int          X_EN_BIT   = 15;
    localparam int          Y_EN_BIT   = 14;
    localparam int          XSEL_LSB   = 0;
    localparam int          YSEL_LSB   = 4;
    localparam logic [3:0]  SEL_OFF    = 4'hf;
    localparam logic [3:0]  MAC_X0     = 4'h8;
    localparam logic [3:0]  MAC_XI     = 4'h9;
    localparam logic [3:0]  MAC_Y0     = 4'ha;
    localparam logic [3:0]  MAC_YI     = 4'hb;

    // ***************************************************
    // modes, classes and carriers
    // ***************************************************
    typedef enum logic [3:0] {
        AM_DIR = 4'h0, AM_IND = 4'h1, AM_POST_INC = 4'h2,
        AM_POST_DEC = 4'h3, AM_PRE_INC = 4'h4,
        AM_PRE_DEC = 4'h5, AM_INDEXED = 4'h6,
        AM_LIT_OFF = 4'h7, AM_LIT8 = 4'h8, AM_LIT16 = 4'h9,
        AM_ADD2 = 4'ha, AM_ADD4 = 4'hb, AM_ADD6 = 4'hc
    } ama_mode_type;

    typedef enum logic [1:0] {
        CL_MOVE = 2'h0, CL_MAC = 2'h1,
        CL_BRA = 2'h2, CL_HOLD = 2'h3
    } ama_class_type;

    typedef struct packed {
        logic          valid;
        ama_class_type cls;
        logic          word;
        ama_mode_type  src_mode;
        logic [3:0]    src_reg;
        ama_mode_type  dst_mode;
        logic [3:0]    dst_reg;
        logic [3:0]    shared_offset_field;
        logic [15:0]   src_val;
        logic [15:0]   dst_val;
        logic [15:0]   offset_val;
        logic [15:0]   literal;
    } ama_req_type;

    typedef struct packed {
        logic        x_rd_valid;
        logic [15:0] x_rd_addr;
        logic        x_wr_valid;
        logic [15:0] x_wr_addr;
        logic        y_valid;
        logic [15:0] y_addr;
        logic        wb_a_en;
        logic [3:0]  wb_a_reg;
        logic [15:0] wb_a_val;
        logic        wb_b_en;
        logic [3:0]  wb_b_reg;
        logic [15:0] wb_b_val;
        logic        lit_valid;
        logic [15:0] lit_val;
        logic [15:0] branch_disp;
        logic [13:0] hold_count;
        logic        illegal;
    } ama_res_type;

    typedef struct packed {
        logic        ea_v;
        logic [15:0] ea;
        logic        wb;
        logic [15:0] newp;
        logic        wrap;
    } ama_op_type;

endpackage : ama_pkg

// File: logic/ama_agu.sv
/*
 * address generator with circular buffer support for
 * the x read, x write and y generators.
 * assumes the decoder presents at most one request per
 * clock with register values already read out.
 */
`timescale 1ns/10ps
module ama_agu
    import ama_pkg::*;
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // register port
    input  wire logic [2:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [15:0] reg_rdata_out,
    // decoder request and result
    input  wire ama_req_type req_in,
    output ama_res_type      res_out
);

    // ***************************************************
    // register file
    // ***************************************************
    logic [15:0] modulo_bitrev_control;
    logic [15:0] x_buffer_start;
    logic [15:0] x_buffer_end;
    logic [15:0] y_buffer_start;
    logic [15:0] y_buffer_end;
    logic [15:0] next_ctrl;
    logic [15:0] next_xs;
    logic [15:0] next_xe;
    logic [15:0] next_ys;
    logic [15:0] next_ye;
    logic [15:0] next_rdata;
    logic [15:0] status;
    ama_res_type res;
    ama_res_type next_res;
    logic        x_wrap_seen;
    logic        y_wrap_seen;
    logic        next_x_wrap;
    logic        next_y_wrap;

    // decoded control fields
    logic [3:0]  x_pointer_select;
    logic [3:0]  y_pointer_select;
    logic        x_circular_enable;
    logic        y_circular_enable;
    logic        x_on;
    logic        y_on;

    assign x_pointer_select  = modulo_bitrev_control[XSEL_LSB +: 4];
    assign y_pointer_select  = modulo_bitrev_control[YSEL_LSB +: 4];
    assign x_circular_enable = modulo_bitrev_control[X_EN_BIT];
    assign y_circular_enable = modulo_bitrev_control[Y_EN_BIT];
    // the all-ones select turns off both x generators
    assign x_on = x_circular_enable &&
                  (x_pointer_select != SEL_OFF); // [R13]
    assign y_on = y_circular_enable &&
                  (y_pointer_select != SEL_OFF); // [R14]

    // status: last wraps, last fault, bad buffer bounds
    assign status = {11'h000,
                     (y_buffer_end < y_buffer_start), // [R11]
                     (x_buffer_end < x_buffer_start), // [R11]
                     res.illegal, y_wrap_seen, x_wrap_seen};

    // writes and the one-cycle-late read data
    always_comb begin
        next_ctrl  = modulo_bitrev_control;
        next_xs    = x_buffer_start; // [R10]
        next_xe    = x_buffer_end;
        next_ys    = y_buffer_start;
        next_ye    = y_buffer_end;
        next_rdata = 16'h0000;
        if (reg_wr_in) begin
            case (reg_addr_in)
                CTRL_IDX: next_ctrl = reg_wdata_in;
                XS_IDX:   next_xs   = reg_wdata_in;
                XE_IDX:   next_xe   = reg_wdata_in;
                YS_IDX:   next_ys   = reg_wdata_in;
                YE_IDX:   next_ye   = reg_wdata_in;
                default:  next_ctrl = modulo_bitrev_control;
            endcase
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
                CTRL_IDX: next_rdata = modulo_bitrev_control;
                XS_IDX:   next_rdata = x_buffer_start;
                XE_IDX:   next_rdata = x_buffer_end;
                YS_IDX:   next_rdata = y_buffer_start;
                YE_IDX:   next_rdata = y_buffer_end;
                STAT_IDX: next_rdata = status;
                default:  next_rdata = 16'h0000;
            endcase
        end
    end

    // single buffer pair per space, no second set
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            modulo_bitrev_control <= CTRL_RESET;
            x_buffer_start        <= BUF_RESET; // [R8]
            x_buffer_end          <= BUF_RESET;
            y_buffer_start        <= BUF_RESET;
            y_buffer_end          <= BUF_RESET;
            reg_rdata_out         <= 16'h0000;
        end else begin
            modulo_bitrev_control <= next_ctrl;
            x_buffer_start        <= next_xs;
            x_buffer_end          <= next_xe;
            y_buffer_start        <= next_ys;
            y_buffer_end          <= next_ye;
            reg_rdata_out         <= next_rdata;
        end
    end

    // ***************************************************
    // operand address arithmetic
    // ***************************************************
    // the end bound is tested on increments and the start bound
    // on decrements, so power of two buffers run either way;
    // odd lengths rely on software using one direction only
    function automatic ama_op_type calc_op(
        input ama_mode_type m,
        input logic [15:0]  p,
        input logic [15:0]  off,
        input logic [15:0]  lit,
        input logic [15:0]  step,
        input logic         mod_on,
        input logic [15:0]  s,
        input logic [15:0]  e,
        input logic         y_sp
    );
        ama_op_type  r;
        logic [15:0] n;
        logic [15:0] len;
        logic        up;
        logic        dn;
        logic        pre;
        r   = '0;
        n   = p;
        up  = 1'b0;
        dn  = 1'b0;
        pre = 1'b0;
        len = e - s + 16'h0001; // [R11]
        case (m)
            AM_IND: r.ea_v = 1'b1;
            AM_POST_INC: begin
                up = 1'b1;
                n  = p + step;
            end
            AM_ADD2: begin
                up = 1'b1;
                n  = p + 16'h0002; // [R3]
            end
            AM_ADD4: begin
                up = 1'b1;
                n  = p + 16'h0004; // [R3]
            end
            AM_ADD6: begin
                up = 1'b1;
                n  = p + 16'h0006; // [R3]
            end
            AM_POST_DEC: begin
                dn = 1'b1;
                n  = p - step;
            end
            AM_PRE_INC: begin
                up  = 1'b1;
                pre = 1'b1;
                n   = p + step;
            end
            AM_PRE_DEC: begin
                dn  = 1'b1;
                pre = 1'b1;
                n   = p - step;
            end
            AM_INDEXED: r.ea_v = 1'b1;
            AM_LIT_OFF: r.ea_v = 1'b1;
            default:    r.ea_v = 1'b0;
        endcase
        // past the end reloads from the start side and
        // below the start reloads from the end side
        if (mod_on && up && (n > e)) begin
            n      = n - len; // [R18] [R16]
            r.wrap = 1'b1;
        end
        if (mod_on && dn && (n < s)) begin
            n      = n + len; // [R18] [R16]
            r.wrap = 1'b1;
        end
        r.ea = pre ? n : p;
        if (m == AM_INDEXED) begin
            r.ea = p + off;
        end
        if (m == AM_LIT_OFF) begin
            r.ea = p + lit;
        end
        if (up || dn) begin
            r.ea_v = 1'b1;
        end
        // word data only in y, so the low bit is dropped
        if (y_sp && mod_on) begin
            r.ea[0] = 1'b0; // [R12]
        end
        r.wb   = up || dn;
        r.newp = n;
        return r;
    endfunction : calc_op

    // ***************************************************
    // request decode
    // ***************************************************
    ama_op_type  op_a;
    ama_op_type  op_b;
    logic [15:0] step;
    logic        a_in_y;
    logic        hit_a;
    logic        hit_b;
    logic        bad;
    logic        mac;

    always_comb begin
        mac  = req_in.cls == CL_MAC;
        step = req_in.word ? 16'h0002 : 16'h0001;
        // the x side also carries program space pointers,
        // so program fetches wrap through the x buffer
        a_in_y = 1'b0; // [R9]
        // only the register named by the select is fixed up
        hit_a = x_on &&
                (req_in.src_reg == x_pointer_select); // [R19]
        // mac second operand lives in y, move dest in x
        hit_b = mac ?
                (y_on && (req_in.dst_reg == y_pointer_select))
              : (x_on && (req_in.dst_reg == x_pointer_select));
        // the offset register value serves both operands
        op_a = calc_op(req_in.src_mode, req_in.src_val,
                       req_in.offset_val, req_in.literal,
                       step, hit_a, x_buffer_start,
                       x_buffer_end, a_in_y); // [R4] [R5]
        op_b = calc_op(req_in.dst_mode, req_in.dst_val,
                       req_in.offset_val, req_in.literal,
                       step, hit_b,
                       mac ? y_buffer_start : x_buffer_start,
                       mac ? y_buffer_end : x_buffer_end,
                       mac); // [R17]
        bad = 1'b0;
        if (mac) begin
            // prefetch pointers fixed to w8..w11
            if (req_in.src_reg[3:1] != MAC_X0[3:1] ||
                req_in.dst_reg[3:1] != MAC_Y0[3:1]) begin
                bad = 1'b1; // [R1]
            end
            if (!(req_in.src_mode inside {AM_IND,
                  AM_INDEXED, AM_ADD2, AM_ADD4, AM_ADD6}) ||
                !(req_in.dst_mode inside {AM_IND,
                  AM_INDEXED, AM_ADD2, AM_ADD4, AM_ADD6})) begin
                bad = 1'b1; // [R3]
            end
            if ((req_in.src_mode == AM_INDEXED &&
                 req_in.src_reg != MAC_XI) ||
                (req_in.dst_mode == AM_INDEXED &&
                 req_in.dst_reg != MAC_YI)) begin
                bad = 1'b1; // [R2]
            end
        end else if (req_in.cls == CL_MOVE) begin
            if (req_in.src_mode > AM_LIT16 ||
                req_in.dst_mode > AM_LIT_OFF) begin
                bad = 1'b1; // [R6]
            end
        end
    end

    // ***************************************************
    // result staging
    // ***************************************************
    always_comb begin
        next_res             = '0;
        next_x_wrap          = x_wrap_seen;
        next_y_wrap          = y_wrap_seen;
        next_res.x_rd_addr   = op_a.ea;
        next_res.x_wr_addr   = op_b.ea;
        next_res.y_addr      = op_b.ea;
        next_res.wb_a_reg    = req_in.src_reg;
        next_res.wb_a_val    = op_a.newp;
        next_res.wb_b_reg    = req_in.dst_reg;
        next_res.wb_b_val    = op_b.newp;
        // literals: branch signed, hold count unsigned
        next_res.branch_disp = req_in.literal; // [R7]
        next_res.hold_count  = req_in.literal[13:0]; // [R7]
        next_res.lit_val     = req_in.literal;
        if (req_in.src_mode == AM_LIT8) begin
            next_res.lit_val = {8'h00, req_in.literal[7:0]};
        end
        if (req_in.valid) begin
            next_res.illegal = bad;
            case (req_in.cls)
                CL_MOVE: begin
                    next_res.x_rd_valid = op_a.ea_v && !bad;
                    next_res.x_wr_valid = op_b.ea_v && !bad;
                    next_res.wb_a_en    = op_a.wb && !bad;
                    next_res.wb_b_en    = op_b.wb && !bad;
                    next_res.lit_valid  = !bad &&
                        (req_in.src_mode inside
                         {AM_LIT8, AM_LIT16}); // [R6]
                    next_x_wrap = op_a.wrap || op_b.wrap;
                    next_y_wrap = 1'b0;
                end
                CL_MAC: begin
                    // x read gets w8/w9, y gets w10/w11
                    next_res.x_rd_valid = !bad; // [R1]
                    next_res.y_valid    = !bad; // [R1]
                    next_res.wb_a_en    = op_a.wb && !bad;
                    next_res.wb_b_en    = op_b.wb && !bad;
                    next_x_wrap = op_a.wrap;
                    next_y_wrap = op_b.wrap;
                end
                CL_BRA: next_res.lit_valid = 1'b1;
                CL_HOLD: next_res.lit_valid = 1'b1;
                default: next_res.illegal = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            res         <= '0;
            x_wrap_seen <= 1'b0;
            y_wrap_seen <= 1'b0;
        end else begin
            res         <= next_res;
            x_wrap_seen <= next_x_wrap;
            y_wrap_seen <= next_y_wrap;
        end
    end

    assign res_out = res;

    // ***************************************************
    // checks
    // ***************************************************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    logic go;
    assign go = req_in.valid;

    mac_route_a: assert property (go && mac && // [R1]
        req_in.src_reg == MAC_X0 && req_in.src_mode == AM_IND &&
        req_in.dst_reg == MAC_Y0 && req_in.dst_mode == AM_IND
        |=> res.x_rd_valid && res.y_valid && !res.x_wr_valid &&
        res.x_rd_addr == $past(req_in.src_val))
        else $error("mac operands not routed");

    mac_index_a: assert property (go && mac && // [R2]
        req_in.src_reg == MAC_X0 &&
        req_in.src_mode == AM_INDEXED
        |=> res.illegal && !res.x_rd_valid)
        else $error("indexed mac via wrong register");

    mac_step_a: assert property (go && mac && !x_on && // [R3]
        req_in.src_reg == MAC_X0 && req_in.src_mode == AM_ADD4 &&
        req_in.dst_reg == MAC_Y0 && req_in.dst_mode == AM_IND
        |=> res.wb_a_en &&
        res.wb_a_val == $past(req_in.src_val) + 16'h0004)
        else $error("mac post step wrong");

    move_off_a: assert property (go && req_in.cls == CL_MOVE && // [R4]
        req_in.src_mode == AM_INDEXED &&
        req_in.dst_mode == AM_INDEXED
        |=> res.x_rd_addr - res.x_wr_addr ==
        $past(req_in.src_val) - $past(req_in.dst_val))
        else $error("shared offset not shared");

    hold_lit_a: assert property (go && req_in.cls == CL_HOLD // [R7]
        |=> res.lit_valid && !res.x_rd_valid &&
        res.hold_count == $past(req_in.literal[13:0]))
        else $error("hold literal wrong");

    y_lsb_a: assert property (go && mac && y_on && // [R12]
        req_in.dst_reg == y_pointer_select
        |=> !res.y_addr[0])
        else $error("y modulo address odd");

    x_off_a: assert property (go && req_in.cls == CL_MOVE && // [R13]
        x_pointer_select == SEL_OFF &&
        req_in.src_mode == AM_POST_INC
        |=> res.wb_a_val == $past(req_in.src_val) +
        ($past(req_in.word) ? 16'h0002 : 16'h0001))
        else $error("x modulo active while off");

    wrap_up_a: assert property (go && req_in.cls == CL_MOVE && // [R18]
        x_on && req_in.word && req_in.src_reg == x_pointer_select &&
        req_in.src_mode == AM_POST_INC &&
        x_buffer_start < x_buffer_end &&
        req_in.src_val == x_buffer_end - 16'h0001
        |=> res.wb_a_val == $past(x_buffer_start) &&
        x_wrap_seen)
        else $error("x pointer did not wrap to start");

    other_reg_a: assert property (go && req_in.cls == CL_MOVE && // [R19]
        x_on && req_in.src_reg != x_pointer_select &&
        req_in.src_mode == AM_POST_DEC && req_in.word
        |=> res.wb_a_val == $past(req_in.src_val) - 16'h0002)
        else $error("unselected pointer corrected");

endmodule : ama_agu

// File: test/ama_dec_model.sv
/*
 * decoder and working register model that feeds the address
 * generator one request at a time and takes pointer updates back.
 * assumes it shares the core clock and reset with the block.
 */
`timescale 1ns/10ps
module ama_dec_model
    import ama_pkg::*;
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // result back, request out
    input  wire ama_res_type res_in,
    output ama_req_type      req_out
);
    logic [15:0] wreg [16];

    initial req_out = '0;

    // pointer value, taking the update still in flight first,
    // because the bench issues at the same edge the update lands
    function automatic logic [15:0] rv(input logic [3:0] r);
        if (res_in.wb_a_en && res_in.wb_a_reg == r) return res_in.wb_a_val;
        if (res_in.wb_b_en && res_in.wb_b_reg == r) return res_in.wb_b_val;
        return wreg[r];
    endfunction : rv

    // one word request held for exactly one edge; any register may
    // serve as a circular pointer, software picks the direction
    task automatic issue(input ama_class_type c, input ama_mode_type sm,
        input logic [3:0] sr, input ama_mode_type dm, input logic [3:0] dr,
        input logic [15:0] off, input logic [15:0] lit);
        ama_req_type r;
        r = '0;
        r.valid = 1'b1;
        r.cls = c;
        r.word = 1'b1;
        r.src_mode = sm;
        r.src_reg = sr;
        r.dst_mode = dm;
        r.dst_reg = dr;
        r.src_val = rv(sr);
        r.dst_val = rv(dr);
        r.offset_val = off;
        r.literal = lit;
        req_out <= r;
        @(posedge clk_in);
        req_out <= '0;
    endtask : issue

    // register file takes the pointer updates
    always @(posedge clk_in) begin
        if (rst_n_in && res_in.wb_a_en)
            wreg[res_in.wb_a_reg] <= res_in.wb_a_val;
        if (rst_n_in && res_in.wb_b_en)
            wreg[res_in.wb_b_reg] <= res_in.wb_b_val;
    end
endmodule : ama_dec_model

// File: test/ama_agu_tb_top.sv
/*
 * self-checking bench for the address generator: register port
 * tasks, decoder model and request scenarios with expected values.
 * assumes a 20 MHz core clock and an active-low reset.
 */
`timescale 1ns/10ps
module ama_agu_tb_top
    import ama_pkg::*;
;
    // ****************************************************
    // signals and instances
    // ****************************************************
    logic        clk_in       = 1'b0;
    logic        rst_n_in     = 1'b0;
    logic [2:0]  reg_addr_in  = 3'h0;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic        reg_wr_in    = 1'b0;
    logic        reg_rd_in    = 1'b0;
    logic [15:0] reg_rdata_out;
    ama_req_type req;
    ama_res_type res;
    int          n_fail       = 0;
    int          cmp_count    = 0;
    logic [15:0] offv [2]     = '{16'h0001, 16'h800f};
    ama_mode_type mac_m [3]   = '{AM_ADD2, AM_ADD4, AM_ADD6};
    logic [15:0] yexp [3]     = '{16'h2000, 16'h2002, 16'h2006};

    always #25 clk_in = ~clk_in;

    ama_agu dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .req_in(req), .res_out(res));
    ama_dec_model u_dec (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .res_in(res), .req_out(req));

    // ****************************************************
    // compare, access and closing tasks
    // ****************************************************
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic chk_bit(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk("reg_rdata_out", e, reg_rdata_out);
    endtask : rd

    // result is sampled in the one cycle it stands
    task automatic go(input ama_class_type c, input ama_mode_type sm,
        input logic [3:0] sr, input ama_mode_type dm, input logic [3:0] dr,
        input logic [15:0] off, input logic [15:0] lit);
        @(posedge clk_in);
        u_dec.issue(c, sm, sr, dm, dr, off, lit);
        #1;
    endtask : go

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    // watchdog: the sequence needs about a hundred cycles
    initial begin
        repeat (3000) @(posedge clk_in);
        n_fail++;
        close_out();
    end

    // ****************************************************
    // scenarios
    // ****************************************************
    initial begin
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(CTRL_IDX, CTRL_RESET);
        rd(XE_IDX, BUF_RESET);
        wr(XS_IDX, 16'h1100);
        wr(XE_IDX, 16'h1163);
        wr(YS_IDX, 16'h2000);
        wr(YE_IDX, 16'h203f);
        rd(XS_IDX, 16'h1100);
        rd(YE_IDX, 16'h203f);
        rd(3'h6, 16'h0000);
        // x buffer on w1: past the end, then below the start
        wr(CTRL_IDX, 16'h8001);
        u_dec.wreg[1] = 16'h1162;
        u_dec.wreg[2] = 16'h1162;
        go(CL_MOVE, AM_POST_INC, 4'h1, AM_DIR, 4'h0, 16'h0000, 16'h0000);
        chk("x_rd_addr", 16'h1162, res.x_rd_addr);
        chk("wb_a_val", 16'h1100, res.wb_a_val);
        rd(STAT_IDX, 16'h0001);
        go(CL_MOVE, AM_PRE_DEC, 4'h1, AM_DIR, 4'h0, 16'h0000, 16'h0000);
        chk("x_rd_addr", 16'h1162, res.x_rd_addr);
        go(CL_MOVE, AM_POST_INC, 4'h2, AM_DIR, 4'h0, 16'h0000, 16'h0000);
        chk("wb_a_val", 16'h1164, res.wb_a_val);
        go(CL_MOVE, AM_POST_DEC, 4'h2, AM_DIR, 4'h0, 16'h0000, 16'h0000);
        chk("wb_a_val", 16'h1162, res.wb_a_val);
        // enable bit low or select all ones: no correction
        foreach (offv[i]) begin
            wr(CTRL_IDX, offv[i]);
            u_dec.wreg[1] = 16'h1162;
            go(CL_MOVE, AM_POST_INC, 4'h1, AM_DIR, 4'h0, 16'h0000, 16'h0000);
            chk("wb_a_val", 16'h1164, res.wb_a_val);
        end
        wr(CTRL_IDX, 16'h800e);
        u_dec.wreg[14] = 16'h1162;
        go(CL_MOVE, AM_POST_INC, 4'he, AM_DIR, 4'h0, 16'h0000, 16'h0000);
        chk("wb_a_val", 16'h1100, res.wb_a_val);
        // dual operand fetches, y buffer on w10
        wr(CTRL_IDX, 16'h40af);
        u_dec.wreg[8] = 16'h0100;
        u_dec.wreg[9] = 16'h0100;
        u_dec.wreg[10] = 16'h2001;
        u_dec.wreg[11] = 16'h2000;
        go(CL_MAC, AM_IND, 4'h8, AM_IND, 4'ha, 16'h0000, 16'h0000);
        chk("x_rd_addr", 16'h0100, res.x_rd_addr);
        chk("y_addr", 16'h2000, res.y_addr);
        chk_bit("y_valid", 1'b1, res.y_valid);
        u_dec.wreg[10] = 16'h203c;
        go(CL_MAC, AM_INDEXED, 4'h9, AM_ADD6, 4'ha, 16'h0010, 16'h0000);
        chk("x_rd_addr", 16'h0110, res.x_rd_addr);
        chk("y_addr", 16'h203c, res.y_addr);
        chk("wb_b_val", 16'h2002, res.wb_b_val);
        foreach (mac_m[i]) begin
            go(CL_MAC, AM_IND, 4'h8, mac_m[i], 4'hb, 16'h0000, 16'h0000);
            chk("y_addr", yexp[i], res.y_addr);
        end
        chk("wb_b_val", 16'h200c, res.wb_b_val);
        go(CL_MAC, AM_ADD4, 4'h8, AM_IND, 4'ha, 16'h0000, 16'h0000);
        chk("wb_a_val", 16'h0104, res.wb_a_val);
        go(CL_MAC, AM_INDEXED, 4'h8, AM_IND, 4'ha, 16'h0004, 16'h0000);
        chk_bit("illegal", 1'b1, res.illegal);
        chk_bit("x_rd_valid", 1'b0, res.x_rd_valid);
        go(CL_MAC, AM_IND, 4'ha, AM_IND, 4'hb, 16'h0000, 16'h0000);
        chk_bit("illegal", 1'b1, res.illegal);
        // move with different source and destination modes
        wr(CTRL_IDX, 16'h00ff);
        u_dec.wreg[3] = 16'h0300;
        u_dec.wreg[4] = 16'h0400;
        go(CL_MOVE, AM_IND, 4'h3, AM_INDEXED, 4'h4, 16'h0020, 16'h0000);
        chk("x_rd_addr", 16'h0300, res.x_rd_addr);
        chk("x_wr_addr", 16'h0420, res.x_wr_addr);
        // every source mode: only pointer modes form an address
        u_dec.wreg[5] = 16'h0500;
        for (int m = 0; m < 13; m++) begin
            go(CL_MOVE, ama_mode_type'(m), 4'h5, AM_INDEXED, 4'h4, 16'h0000,
                16'h1234);
            chk_bit("x_rd_valid", m >= 1 && m <= 7, res.x_rd_valid);
        end
        go(CL_MOVE, AM_LIT8, 4'h0, AM_DIR, 4'h0, 16'h0000, 16'h1234);
        chk("lit_val", 16'h0034, res.lit_val);
        chk_bit("lit_valid", 1'b1, res.lit_valid);
        go(CL_BRA, AM_DIR, 4'h0, AM_DIR, 4'h0, 16'h0000, 16'h8000);
        chk("branch_disp", 16'h8000, res.branch_disp);
        go(CL_HOLD, AM_DIR, 4'h0, AM_DIR, 4'h0, 16'h0000, 16'hffff);
        chk("hold_count", 16'h3fff, {2'h0, res.hold_count});
        close_out();
    end
endmodule : ama_agu_tb_top
